// *** tsp_timer.sv ***
// Dual channel timer: single pulse output and input capture modes.
// Assumes pins and strobes synchronous to clk_in; data one cycle after rd.
//
// Operation
// - Run rising starts counter, channel A pulse.
// - Comparator B match starts channel B pulse.
// - Trigger pin edge sets run bit.
// - Counting and channel A leading edge coincide.
// - Software run clear ends both pulses.
// - Comparator A match clears run, ends pulses.
// - A width cmp A, B width A minus B.
// - A and B matches raise flags.
// - Counter zeroed only on run rising.
// - Period and clear select ignored there.
// - Pin-control picks rise, fall or both.
// - Capture: run rising starts the counter.
// - Selected edge copies count, raises flag.
// - Counter free-runs until run falls.
// - Period match zeroes counter, raises flag.
// - Period code zero gives largest range.
// - Pin-control 11 disables capture only.
// - Clear select, level, polarity ignored.
// - Pin driven as output still captures.
// - Period codes 1..7 times 128, 0=1024.
`timescale 1ns/1ns
module tsp_timer
   import tsp_pkg::*;
#(
   parameter int CNT_W = 10,
   parameter int DAT_W = 16
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic ce_in,
   input wire logic [2:0] addr_in,
   input wire logic [DAT_W-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic chan_a_pin_in,
   input wire logic chan_b_pin_alt0_in,
   input wire logic chan_b_pin_alt1_in,
   input wire logic ext_trigger_pin_in,
   output logic [DAT_W-1:0] rdata_out,
   output logic chan_a_pin_out,
   output logic chan_b_pin_out,
   output logic [2:0] flags_out
);
   // Software state
   logic [5:0] ctl_a_q;
   logic [5:0] ctl_b_q;
   logic run_q;
   logic cclr_q; // Kept for readback only
   logic [2:0] per_q;
   logic [CNT_W-1:0] cmp_a_q;
   logic [CNT_W-1:0] cmp_b_q;
   // Timer state
   logic [CNT_W-1:0] cnt_q;
   logic pulse_a_q;
   logic pulse_b_q;
   logic [2:0] flag_q;
   // Previous pin levels for edge detection
   logic pa_q, pb0_q, pb1_q, trg_q;
   logic [DAT_W-1:0] rdata_q;
   logic out_a_q, out_b_q;

   // Field decode
   wire logic [1:0] mode_a = ctl_a_q[TSP_MODE_LSB +: 2];
   wire logic [1:0] mode_b = ctl_b_q[TSP_MODE_LSB +: 2];
   wire logic [1:0] pc_a = ctl_a_q[TSP_PCTL_LSB +: 2];
   wire logic [1:0] pc_b = ctl_b_q[TSP_PCTL_LSB +: 2];
   wire logic sp_mode = (mode_a == TSP_MODE_SP) && (mode_b == TSP_MODE_SP);
   wire logic cap_mode = (mode_a == TSP_MODE_CAP) && (mode_b == TSP_MODE_CAP);

   // Register strobes
   wire logic wr_ctl_a = wr_in && (addr_in == TSP_CTL_A);
   wire logic wr_ctl_b = wr_in && (addr_in == TSP_CTL_B);
   wire logic wr_run = wr_in && (addr_in == TSP_RUN);
   wire logic wr_cmp_a = wr_in && (addr_in == TSP_CMP_A);
   wire logic wr_cmp_b = wr_in && (addr_in == TSP_CMP_B);
   wire logic wr_flags = wr_in && (addr_in == TSP_FLAGS);
   wire logic wr_run_one = wr_run && wdata_in[TSP_RUN_BIT];
   wire logic wr_run_zero = wr_run && !wdata_in[TSP_RUN_BIT];

   // Trigger pin: rising edge taken as the active edge
   // History resets low like the idle pin, so reset gives no false start
   wire logic trg_edge = ext_trigger_pin_in && !trg_q;
   // Start happens only from a stopped counter
   wire logic start_w = !run_q && (wr_run_one || (sp_mode && trg_edge));

   // Comparator matches on the next count, so widths come out exact
   // Limitation: a compare value of zero only matches as the count rolls over
   wire logic [CNT_W-1:0] cnt_inc = cnt_q + 1'b1;
   wire logic match_a = run_q && (cnt_inc == cmp_a_q);
   wire logic match_b = run_q && (cnt_inc == cmp_b_q);

   // Period limit: code times step, code zero wraps the full range
   // A code lowered below a running count rolls over at the full range
   wire logic [CNT_W:0] per_lim = (per_q == 3'h0) ? (CNT_W+1)'(1 << CNT_W)
      : (CNT_W+1)'(per_q * TSP_PER_STEP);
   wire logic match_p = run_q && ({1'b0, cnt_q} == per_lim - 1'b1);

   // Edge selection per pin-control code
   // Edges are judged against last cycle's sample, so pins must be synchronous
   function automatic logic edge_sel(input logic [1:0] pc, input logic now,
      input logic prev);
      logic rise, fall;
      rise = now && !prev;
      fall = !now && prev;
      unique case (pc)
         TSP_PC_RISE: edge_sel = rise;
         TSP_PC_FALL: edge_sel = fall;
         TSP_PC_BOTH: edge_sel = rise || fall;
         TSP_PC_OFF: edge_sel = 1'b0;
      endcase
   endfunction

   // Pin levels are used whatever drives them, so outputs capture too
   wire logic cap_a = cap_mode && edge_sel(pc_a, chan_a_pin_in, pa_q);
   wire logic cap_b = cap_mode && (edge_sel(pc_b, chan_b_pin_alt0_in, pb0_q)
      || edge_sel(pc_b, chan_b_pin_alt1_in, pb1_q));

   // Stop: software clear or comparator A in pulse mode
   wire logic stop_w = run_q && (wr_run_zero || (sp_mode && match_a));

   // Flag set sources
   wire logic [2:0] flag_set = {cap_mode && match_p,
      (sp_mode && match_b) || cap_b, (sp_mode && match_a) || cap_a};

   // Readback mux
   logic [DAT_W-1:0] rd_mux;
   always_comb begin
      rd_mux = TSP_RST_WORD;
      unique case (addr_in)
         TSP_CTL_A: rd_mux = DAT_W'(ctl_a_q);
         TSP_CTL_B: rd_mux = DAT_W'(ctl_b_q);
         TSP_RUN: rd_mux = DAT_W'({per_q, cclr_q, run_q});
         TSP_CMP_A: rd_mux = DAT_W'(cmp_a_q);
         TSP_CMP_B: rd_mux = DAT_W'(cmp_b_q);
         TSP_COUNT: rd_mux = DAT_W'(cnt_q);
         TSP_FLAGS: rd_mux = DAT_W'(flag_q);
         default: rd_mux = TSP_RST_WORD; // Unmapped reads zero
      endcase
   end

   // Control registers
   // Level bit is kept for readback only; it drives nothing in these modes
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         ctl_a_q <= '0;
         ctl_b_q <= '0;
         cclr_q <= 1'b0;
         per_q <= 3'h0;
      end else if (ce_in) begin
         if (wr_ctl_a) ctl_a_q <= wdata_in[5:0];
         if (wr_ctl_b) ctl_b_q <= wdata_in[5:0];
         if (wr_run) begin
            cclr_q <= wdata_in[TSP_CCLR_BIT];
            per_q <= wdata_in[TSP_PER_LSB +: 3];
         end
      end
   end

   // Run bit: start by software or trigger, stop by clear or match A
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         run_q <= 1'b0;
      end else if (ce_in) begin
         if (start_w) run_q <= 1'b1;
         else if (stop_w) run_q <= 1'b0;
      end
   end

   // Counter: zero on start, count while running, hold when stopped
   // Start comes first so a restart never sees a stale period match
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         cnt_q <= '0;
      end else if (ce_in) begin
         if (start_w) cnt_q <= '0;
         else if (run_q && cap_mode && match_p) cnt_q <= '0;
         else if (run_q) cnt_q <= cnt_inc;
         // Otherwise held
      end
   end

   // Compare registers; a capture beats a software write
   // Trade-off: a write racing a capture is lost, never the measurement
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         cmp_a_q <= '0;
         cmp_b_q <= '0;
      end else if (ce_in) begin
         if (cap_a) cmp_a_q <= cnt_q;
         else if (wr_cmp_a) cmp_a_q <= wdata_in[CNT_W-1:0];
         if (cap_b) cmp_b_q <= cnt_q;
         else if (wr_cmp_b) cmp_b_q <= wdata_in[CNT_W-1:0];
      end
   end

   // Pulse shapers: only active in single pulse mode
   // Leaving pulse mode drops both pulses at once
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         pulse_a_q <= 1'b0;
         pulse_b_q <= 1'b0;
      end else if (ce_in) begin
         if (!sp_mode || stop_w) begin
            pulse_a_q <= 1'b0;
            pulse_b_q <= 1'b0;
         end else if (start_w) begin
            pulse_a_q <= 1'b1;
            pulse_b_q <= 1'b0;
         end else if (match_b) begin
            pulse_b_q <= 1'b1;
         end
      end
   end

   // Flags: write one clears, a same-cycle set wins
   // Write one to clear cannot wipe a flag that software has not yet seen
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         flag_q <= 3'h0;
      end else if (ce_in) begin
         flag_q <= (flag_q & ~(wr_flags ? wdata_in[2:0] : 3'h0)) | flag_set;
      end
   end

   // Pin history, read data and output flops
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         pa_q <= 1'b0;
         pb0_q <= 1'b0;
         pb1_q <= 1'b0;
         trg_q <= 1'b0;
         rdata_q <= TSP_RST_WORD;
         out_a_q <= 1'b0;
         out_b_q <= 1'b0;
      end else if (ce_in) begin
         pa_q <= chan_a_pin_in;
         pb0_q <= chan_b_pin_alt0_in;
         pb1_q <= chan_b_pin_alt1_in;
         trg_q <= ext_trigger_pin_in;
         rdata_q <= rd_in ? rd_mux : TSP_RST_WORD;
         // Polarity bit inverts the pulse; it means nothing in capture mode
         out_a_q <= sp_mode && (pulse_a_q ^ ctl_a_q[TSP_POL_BIT]);
         out_b_q <= sp_mode && (pulse_b_q ^ ctl_b_q[TSP_POL_BIT]);
      end
   end

   assign rdata_out = rdata_q;
   assign chan_a_pin_out = out_a_q;
   assign chan_b_pin_out = out_b_q;
   assign flags_out = flag_q;

   // Checks; frozen cycles are skipped
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in || !ce_in);

   // Pulse mode checks

   start_pulse_a: assert property (sp_mode && start_w |=> pulse_a_q && run_q)
      else $error("pulse A did not start with run");
   count_zero_a: assert property (start_w |=> cnt_q == '0)
      else $error("counter not zero after start");
   run_clear_a: assert property (sp_mode && run_q && wr_run_zero && !start_w
      |=> !pulse_a_q && !pulse_b_q && !run_q)
      else $error("software clear did not end pulses");
   match_stop_a: assert property (sp_mode && match_a
      |=> !run_q && !pulse_a_q && flag_q[TSP_FLG_A])
      else $error("match A did not stop the pulse");
   b_lead_a: assert property (sp_mode && match_b && !stop_w && !start_w
      |=> pulse_b_q)
      else $error("match B did not start pulse B");
   trig_run_a: assert property (sp_mode && trg_edge && !run_q |=> run_q)
      else $error("trigger did not set run");
   sp_no_period_a: assert property (sp_mode && match_p
      |=> cnt_q == $past(cnt_q) + 1'b1)
      else $error("period match moved the pulse counter");
   hold_cnt_a: assert property (!run_q && !start_w |=> $stable(cnt_q))
      else $error("stopped counter moved");
   // Capture mode checks
   cap_latch_a: assert property (cap_a |=> cmp_a_q == $past(cnt_q))
      else $error("capture A missed the count");
   period_wrap_a: assert property (cap_mode && match_p && !start_w
      |=> cnt_q == '0 && flag_q[TSP_FLG_P])
      else $error("period match did not wrap");
   cap_off_a: assert property (cap_mode && pc_a == TSP_PC_OFF && !wr_cmp_a
      |=> $stable(cmp_a_q))
      else $error("capture with edges disabled");
   cap_off_b_a: assert property (cap_mode && pc_b == TSP_PC_OFF && !wr_cmp_b
      |=> $stable(cmp_b_q))
      else $error("capture B with edges disabled");
   cap_step_a: assert property (cap_mode && run_q && !match_p
      |=> cnt_q == $past(cnt_q) + 1'b1)
      else $error("capture counter did not free-run");
   full_range_a: assert property (cap_mode && run_q && per_q == 3'h0
      && cnt_q == CNT_W'(TSP_PER_STEP - 1) |=> cnt_q == CNT_W'(TSP_PER_STEP))
      else $error("code zero wrapped early");

   // Covers for the main scenarios
   sp_done_c: cover property (sp_mode && start_w ##[1:1000] match_a);
   cap_a_c: cover property (cap_mode && run_q && cap_a);
   wrap_c: cover property (cap_mode && match_p);
   trig_start_c: cover property (sp_mode && trg_edge && !run_q);
   cap_b_c: cover property (cap_mode && cap_b);
endmodule

// *** tsp_pkg.sv ***
// Package for the single pulse / capture timer section.
// Assumes one 125 MHz clock and a plain strobe register port.
package tsp_pkg;
   // Register indices on the plain port
   localparam logic [2:0] TSP_CTL_A = 3'h0;
   localparam logic [2:0] TSP_CTL_B = 3'h1;
   localparam logic [2:0] TSP_RUN = 3'h2;
   localparam logic [2:0] TSP_CMP_A = 3'h3;
   localparam logic [2:0] TSP_CMP_B = 3'h4;
   localparam logic [2:0] TSP_COUNT = 3'h5;
   localparam logic [2:0] TSP_FLAGS = 3'h6;
   // Channel control fields
   localparam int TSP_MODE_LSB = 0;
   localparam int TSP_PCTL_LSB = 2;
   localparam int TSP_OLVL_BIT = 4;
   localparam int TSP_POL_BIT = 5;
   // Run register fields
   localparam int TSP_RUN_BIT = 0;
   localparam int TSP_CCLR_BIT = 1;
   localparam int TSP_PER_LSB = 2;
   // Flag bit positions
   localparam int TSP_FLG_A = 0;
   localparam int TSP_FLG_B = 1;
   localparam int TSP_FLG_P = 2;
   // Mode and pin-control codes
   localparam logic [1:0] TSP_MODE_CAP = 2'h1;
   localparam logic [1:0] TSP_MODE_SP = 2'h2;
   localparam logic [1:0] TSP_PC_RISE = 2'h0;
   localparam logic [1:0] TSP_PC_FALL = 2'h1;
   localparam logic [1:0] TSP_PC_BOTH = 2'h2;
   localparam logic [1:0] TSP_PC_OFF = 2'h3;
   // Period comparator step in counts
   localparam int TSP_PER_STEP = 128;
   // Reset values
   localparam logic [15:0] TSP_RST_WORD = 16'h0000;
endpackage

// *** tsp_pin_model.sv ***
// Pin-side partner: drives the capture pins and the trigger pin.
// Assumes its tasks are called just after a rising edge of clk_in.
`timescale 1ns/1ns
module tsp_pin_model (
   input wire logic clk_in,
   output logic chan_a_pin_out,
   output logic chan_b_pin_alt0_out,
   output logic chan_b_pin_alt1_out,
   output logic ext_trigger_pin_out
);
   // Quiet levels until the bench asks for edges
   initial begin
      chan_a_pin_out = 1'b0;
      chan_b_pin_alt0_out = 1'b0;
      chan_b_pin_alt1_out = 1'b0;
      ext_trigger_pin_out = 1'b0;
   end
   // Pins may be shared outputs; the block must still see the edges
   task automatic set_pins(input logic a, input logic b0, input logic b1);
      chan_a_pin_out <= a;
      chan_b_pin_alt0_out <= b0;
      chan_b_pin_alt1_out <= b1;
   endtask
   // One-cycle high pulse; only its rising edge matters
   task automatic trigger();
      ext_trigger_pin_out <= 1'b1;
      @(posedge clk_in);
      ext_trigger_pin_out <= 1'b0;
   endtask
endmodule

// *** timer_single_pulse_capture_tb.sv ***
// Self-checking bench for the single pulse / capture timer.
// Assumes the pin partner model and a 125 MHz clock.
`timescale 1ns/1ns
module timer_single_pulse_capture_tb import tsp_pkg::*; ();
   logic clk_in, nrst_in, wr_in, rd_in, rd_q;
   logic [2:0] addr_in;
   logic [15:0] wdata_in;
   logic a_pin, b0_pin, b1_pin, trig_pin;
   logic [15:0] rdata_out;
   logic chan_a_pin_out, chan_b_pin_out;
   logic [2:0] flags_out;
   int n_fail = 0, total_checks = 0, wa = 0, wb = 0, cyc = 0;
   int t_run, cmp_a, cmp_b, ea, eb;
   logic [15:0] q_rd[$];
   int q_wa[$], q_wb[$];
   // Flag-output notes, one per read; bit 3 marks a flags read
   logic [3:0] q_fl[$];
   logic [3:0] fl;
   // Device under test; clock enable held high
   tsp_timer #(.CNT_W(10), .DAT_W(16)) DUT (.clk_in(clk_in), .nrst_in(nrst_in),
      .ce_in(1'b1), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
      .rd_in(rd_in), .chan_a_pin_in(a_pin), .chan_b_pin_alt0_in(b0_pin),
      .chan_b_pin_alt1_in(b1_pin), .ext_trigger_pin_in(trig_pin),
      .rdata_out(rdata_out), .chan_a_pin_out(chan_a_pin_out),
      .chan_b_pin_out(chan_b_pin_out), .flags_out(flags_out));
   tsp_pin_model pm (.clk_in(clk_in), .chan_a_pin_out(a_pin),
      .chan_b_pin_alt0_out(b0_pin), .chan_b_pin_alt1_out(b1_pin),
      .ext_trigger_pin_out(trig_pin));
   // 8 ns clock
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Strobe tasks leave an idle cycle so no strobe is set twice at one edge
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [15:0] e);
      q_rd.push_back(e);
      q_fl.push_back(a == TSP_FLAGS ? {1'b1, e[2:0]} : 4'h0);
      @(posedge clk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
   endtask
   // Monitor: read data one cycle after the strobe, pulse widths at fall
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      rd_q <= rd_in;
      if (rd_q) begin
         chk(rdata_out, q_rd.size() ? q_rd.pop_front() : 16'hdead);
         fl = q_fl.size() ? q_fl.pop_front() : 4'h0;
         if (fl[3]) chk(16'(flags_out), 16'(fl[2:0]));
      end
      // Outputs are unknown before the first reset edge, so skip reset
      if (!nrst_in) wa = 0;
      else if (chan_a_pin_out !== 1'b0) wa++;
      else if (wa != 0) begin
         chk(16'(wa), q_wa.size() ? 16'(q_wa.pop_front()) : 16'hffff);
         wa = 0;
      end
      if (!nrst_in) wb = 0;
      else if (chan_b_pin_out !== 1'b0) wb++;
      else if (wb != 0) begin
         chk(16'(wb), q_wb.size() ? 16'(q_wb.pop_front()) : 16'hffff);
         wb = 0;
      end
   end
   task automatic report_and_stop();
      if (q_rd.size() + q_wa.size() + q_wb.size() + q_fl.size() != 0) n_fail++;
      if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Watchdog well past the little over a thousand cycles the tests need
   initial begin
      #(8 * 8000);
      n_fail++;
      report_and_stop();
   end
   initial begin
      nrst_in = 1'b0;
      wr_in = 1'b0;
      rd_in = 1'b0;
      addr_in = 3'h0;
      wdata_in = 16'h0000;
      void'($urandom(32'hab0e));
      cmp_a = 150 + int'($urandom % 100);
      cmp_b = 10 + int'($urandom % (cmp_a - 10));
      repeat (8) @(posedge clk_in);
      nrst_in <= 1'b1;
      rd(3'h7, 16'h0000);
      // Single pulse: period code 1 and clear select set, both ignored
      wr(TSP_CTL_A, 16'h000e);
      wr(TSP_CTL_B, 16'h000e);
      wr(TSP_CMP_A, 16'(cmp_a));
      wr(TSP_CMP_B, 16'(cmp_b));
      q_wa.push_back(cmp_a);
      q_wb.push_back(cmp_a - cmp_b);
      wr(TSP_RUN, 16'h0007);
      repeat (cmp_a + 8) @(posedge clk_in);
      q_wa.push_back(cmp_a);
      q_wb.push_back(cmp_a - cmp_b);
      pm.trigger();
      repeat (cmp_a + 8) @(posedge clk_in);
      q_wa.push_back(6);
      wr(TSP_RUN, 16'h0001);
      repeat (4) @(posedge clk_in);
      wr(TSP_RUN, 16'h0000);
      repeat (8) @(posedge clk_in);
      rd(TSP_FLAGS, 16'h0003);
      // Capture: A rising with level and polarity set, B disabled
      wr(TSP_CTL_A, 16'h0031);
      wr(TSP_CTL_B, 16'h000d);
      wr(TSP_CMP_B, 16'h0055);
      wr(TSP_FLAGS, 16'h0007);
      wr(TSP_RUN, 16'h0007);
      t_run = cyc;
      repeat (5 + int'($urandom % 50)) @(posedge clk_in);
      ea = (cyc - t_run) % 128;
      pm.set_pins(1'b1, 1'b0, 1'b0);
      repeat (3) @(posedge clk_in);
      pm.set_pins(1'b1, 1'b1, 1'b1);
      repeat (3) @(posedge clk_in);
      pm.set_pins(1'b1, 1'b0, 1'b1);
      rd(TSP_CMP_B, 16'h0055);
      rd(TSP_CMP_A, 16'(ea));
      wr(TSP_CTL_B, 16'h0005);
      eb = (cyc - t_run) % 128;
      pm.set_pins(1'b1, 1'b0, 1'b0);
      wr(TSP_CTL_A, 16'h0009);
      ea = (cyc - t_run) % 128;
      pm.set_pins(1'b0, 1'b0, 1'b0);
      repeat (130) @(posedge clk_in);
      rd(TSP_CMP_B, 16'(eb));
      rd(TSP_CMP_A, 16'(ea));
      rd(TSP_FLAGS, 16'h0007);
      // Period code zero: a capture past 128 counts shows no early wrap
      wr(TSP_RUN, 16'h0000);
      wr(TSP_RUN, 16'h0001);
      t_run = cyc;
      repeat (300) @(posedge clk_in);
      ea = (cyc - t_run) % 1024;
      pm.set_pins(1'b1, 1'b0, 1'b0);
      rd(TSP_CMP_A, 16'(ea));
      repeat (4) @(posedge clk_in);
      report_and_stop();
   end
endmodule
